// ===== rsse_pkg.sv
package rsse_pkg;

  localparam int          DATA_W      = 8;
  localparam int          INSTR_W     = 14;
  localparam int          ADDR_W      = 10;
  localparam int          FILE_DEPTH  = 128;

  // Byte addresses of the register window
  localparam logic [9:0]  ADR_INSTR   = 10'h000;
  localparam logic [9:0]  ADR_ACCUM   = 10'h004;
  localparam logic [9:0]  ADR_STATUS  = 10'h008;
  localparam logic [9:0]  ADR_WDOG    = 10'h00C;
  localparam logic [9:0]  ADR_RETIRED = 10'h010;
  localparam int          FILE_SEL_BIT = 9;

  // Status field positions
  localparam int          ST_CARRY    = 0;
  localparam int          ST_DCARRY   = 1;
  localparam int          ST_ZERO     = 2;
  localparam int          ST_PDOWN    = 3;
  localparam int          ST_TIMEOUT  = 4;
  localparam int          ST_ASLEEP   = 5;
  localparam int          ST_BUSY     = 6;

  // Opcode fields
  localparam logic [5:0]  OP_ROT_LEFT  = 6'h0D;
  localparam logic [5:0]  OP_ROT_RIGHT = 6'h0C;
  localparam logic [4:0]  OP_SUB_LIT   = 5'h1E;
  localparam logic [13:0] OP_SLEEP     = 14'h0063;
  localparam int          DEST_BIT     = 7;

  localparam logic [7:0]  WDOG_CLEAR_VAL  = 8'h00;
  localparam logic [7:0]  PRESC_CLEAR_VAL = 8'h00;
  localparam logic [7:0]  PRESC_WRAP      = 8'hFF;
  localparam logic [13:0] INSTR_RST       = 14'h0000;
  localparam logic [7:0]  ACCUM_RST       = 8'h00;

  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_DECODE  = 3'b001,
    PH_READ    = 3'b010,
    PH_PROCESS = 3'b011,
    PH_WRITE   = 3'b100
  } rsse_phase_e;

  typedef enum logic [2:0] {
    OPK_NONE  = 3'b000,
    OPK_ROTL  = 3'b001,
    OPK_ROTR  = 3'b010,
    OPK_SUBL  = 3'b011,
    OPK_SLEEP = 3'b100
  } rsse_opk_e;

  typedef struct packed {
    logic timeout;
    logic powerdown;
    logic zero;
    logic digit_carry;
    logic carry;
  } rsse_flags_s;

  localparam rsse_flags_s FLAGS_RST = '{timeout: 1'b1, powerdown: 1'b1, zero: 1'b0,
                                        digit_carry: 1'b0, carry: 1'b0};

endpackage

// ===== rsse_rotate.sv
`timescale 1ns/1ps
`default_nettype none

module rsse_rotate (
  input  wire logic       left_i,
  input  wire logic [7:0] value_i,
  input  wire logic       carry_i,
  output logic      [7:0] result_o,
  output logic            carry_o
);

  always_comb begin
    if (left_i) begin
      result_o = {value_i[6:0], carry_i};
      carry_o  = value_i[7];
    end else begin
      result_o = {carry_i, value_i[7:1]};
      carry_o  = value_i[0];
    end
  end

endmodule // rsse_rotate

`default_nettype wire

// ===== rsse_sub.sv
`timescale 1ns/1ps
`default_nettype none

module rsse_sub (
  input  wire logic [7:0] literal_i,
  input  wire logic [7:0] accum_i,
  output logic      [7:0] result_o,
  output logic            carry_o,
  output logic            digit_carry_o,
  output logic            zero_o
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Two's complement: k + ~w + 1, carry out means no borrow
  assign full_sum      = {1'b0, literal_i} + {1'b0, ~accum_i} + 9'h001;
  assign low_sum       = {1'b0, literal_i[3:0]} + {1'b0, ~accum_i[3:0]} + 5'h01;
  assign result_o      = full_sum[7:0];
  assign carry_o       = full_sum[8];
  assign digit_carry_o = low_sum[4];
  assign zero_o        = (full_sum[7:0] == 8'h00);

endmodule // rsse_sub

`default_nettype wire

// ===== rsse_core.sv
// Operation
// - Rotate-left opcode 1101: shift file register left, carry in bit 0, bit 7 out.
// - Rotate-right opcode 1100: shift right, carry into bit 7, bit 0 out.
// - Destination bit 0 writes accumulator, 1 writes back the file register.
// - Rotates change only carry; zero and digit carry keep their values.
// - Rotate runs one cycle: decode, read register, process, write destination.
// - Power-down recognised by its fixed encoding; no operands, single cycle.
// - Power-down loads watchdog counter with 00h and clears its prescaler.
// - Power-down sets the time-out flag and clears the power-down flag.
// - Power-down stops the oscillator and enters the low-power idle state (here clk_i and the watchdog run on; only instruction starts are blocked).
// - Power-down phases two and three idle; sleep entered in phase four.
// - Literal subtract computes literal minus accumulator into the accumulator.
// - Literal subtract decoded from prefix 11 110x; low byte is the literal.
// - Literal subtract updates carry, digit carry and zero from the result.
// - After subtract, carry is 1 without borrow, 0 with borrow.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module rsse_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             sleep_o,
  output logic             busy_o
);

  rsse_pkg::rsse_phase_e phase_reg;
  rsse_pkg::rsse_phase_e phase_next;
  rsse_pkg::rsse_opk_e   opk_reg;
  rsse_pkg::rsse_opk_e   opk_next;
  rsse_pkg::rsse_flags_s flags_reg;

  logic [13:0] instr_reg;
  logic [7:0]  accum_reg;
  logic [7:0]  operand_reg;
  logic [7:0]  result_reg;
  logic        res_carry_reg;
  logic        res_dcarry_reg;
  logic        res_zero_reg;
  logic        asleep_reg;
  logic [7:0]  watchdog_counter_reg;
  logic [7:0]  presc_reg;
  logic [15:0] retired_reg;
  logic [7:0]  file_mem [0:rsse_pkg::FILE_DEPTH-1];

  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic        sel_file;
  logic [6:0]  file_idx;
  logic        wr_lane0;
  logic        instr_go;
  logic [6:0]  op_addr;
  logic        op_dest;
  logic [7:0]  rot_result;
  logic        rot_carry;
  logic [7:0]  sub_result;
  logic        sub_carry;
  logic        sub_dcarry;
  logic        sub_zero;
  logic        commit;
  logic [7:0]  status_word;
  logic [31:0] rd_data;
  logic [9:0]  reg_adr;
  logic        wake_wr;

  // Bus decode: one-cycle answer, ack dropped the cycle after
  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr   = bus_req && wb_we_i;
  assign bus_rd   = bus_req && !wb_we_i;
  assign sel_file = wb_adr_i[rsse_pkg::FILE_SEL_BIT];
  assign file_idx = wb_adr_i[8:2];
  assign wr_lane0 = bus_wr && wb_sel_i[0];
  // Byte-lane bits of the address are ignored
  assign reg_adr  = {wb_adr_i[9:2], 2'b00};
  assign wake_wr  = wr_lane0 && !sel_file && (reg_adr == rsse_pkg::ADR_STATUS)
                    && !wb_dat_i[rsse_pkg::ST_ASLEEP];

  // Instruction start only from idle and awake
  assign instr_go = bus_wr && !sel_file && (reg_adr == rsse_pkg::ADR_INSTR)
                    && (wb_sel_i[1:0] == 2'b11) && (phase_reg == rsse_pkg::PH_IDLE)
                    && !asleep_reg;

  assign op_addr = instr_reg[6:0];
  assign op_dest = instr_reg[rsse_pkg::DEST_BIT];
  assign commit  = (phase_reg == rsse_pkg::PH_WRITE);

  rsse_rotate u_rotate (
    .left_i   (opk_reg == rsse_pkg::OPK_ROTL),
    .value_i  (operand_reg),
    .carry_i  (flags_reg.carry),
    .result_o (rot_result),
    .carry_o  (rot_carry)
  );

  rsse_sub u_sub (
    .literal_i     (operand_reg),
    .accum_i       (accum_reg),
    .result_o      (sub_result),
    .carry_o       (sub_carry),
    .digit_carry_o (sub_dcarry),
    .zero_o        (sub_zero)
  );

  // Phase sequencer
  always_comb begin
    case (phase_reg)
      rsse_pkg::PH_IDLE:    phase_next = instr_go ? rsse_pkg::PH_DECODE : rsse_pkg::PH_IDLE;
      rsse_pkg::PH_DECODE:  phase_next = rsse_pkg::PH_READ;
      rsse_pkg::PH_READ:    phase_next = rsse_pkg::PH_PROCESS;
      rsse_pkg::PH_PROCESS: phase_next = rsse_pkg::PH_WRITE;
      rsse_pkg::PH_WRITE:   phase_next = rsse_pkg::PH_IDLE;
      default:              phase_next = rsse_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= rsse_pkg::PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Decode
  always_comb begin
    if (instr_reg[13:8] == rsse_pkg::OP_ROT_LEFT) begin
      opk_next = rsse_pkg::OPK_ROTL;
    end else if (instr_reg[13:8] == rsse_pkg::OP_ROT_RIGHT) begin
      opk_next = rsse_pkg::OPK_ROTR;
    end else if (instr_reg[13:9] == rsse_pkg::OP_SUB_LIT) begin
      opk_next = rsse_pkg::OPK_SUBL;
    end else if (instr_reg == rsse_pkg::OP_SLEEP) begin
      opk_next = rsse_pkg::OPK_SLEEP;
    end else begin
      opk_next = rsse_pkg::OPK_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opk_reg <= rsse_pkg::OPK_NONE;
    end else if (phase_reg == rsse_pkg::PH_DECODE) begin
      opk_reg <= opk_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_reg <= rsse_pkg::INSTR_RST;
    end else if (instr_go) begin
      instr_reg <= wb_dat_i[13:0];
    end
  end

  // Read phase: file register or literal; power-down reads nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_reg <= 8'h00;
    end else if (phase_reg == rsse_pkg::PH_READ) begin
      case (opk_reg)
        rsse_pkg::OPK_ROTL,
        rsse_pkg::OPK_ROTR: operand_reg <= file_mem[op_addr];
        rsse_pkg::OPK_SUBL: operand_reg <= instr_reg[7:0];
        default:            operand_reg <= operand_reg;
      endcase
    end
  end

  // Process phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg     <= 8'h00;
      res_carry_reg  <= 1'b0;
      res_dcarry_reg <= 1'b0;
      res_zero_reg   <= 1'b0;
    end else if (phase_reg == rsse_pkg::PH_PROCESS) begin
      case (opk_reg)
        rsse_pkg::OPK_ROTL,
        rsse_pkg::OPK_ROTR: begin
          result_reg    <= rot_result;
          res_carry_reg <= rot_carry;
        end
        rsse_pkg::OPK_SUBL: begin
          result_reg     <= sub_result;
          res_carry_reg  <= sub_carry;
          res_dcarry_reg <= sub_dcarry;
          res_zero_reg   <= sub_zero;
        end
        default: begin
          result_reg <= result_reg;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_reg <= rsse_pkg::ACCUM_RST;
    end else if (commit) begin
      if (opk_reg == rsse_pkg::OPK_SUBL) begin
        accum_reg <= result_reg;
      end else if ((opk_reg == rsse_pkg::OPK_ROTL || opk_reg == rsse_pkg::OPK_ROTR)
                   && !op_dest) begin
        accum_reg <= result_reg;
      end
    end else if (wr_lane0 && !sel_file && reg_adr == rsse_pkg::ADR_ACCUM
                 && phase_reg == rsse_pkg::PH_IDLE) begin
      accum_reg <= wb_dat_i[7:0];
    end
  end

  // File registers
  always_ff @(posedge clk_i) begin
    if (commit && op_dest
        && (opk_reg == rsse_pkg::OPK_ROTL || opk_reg == rsse_pkg::OPK_ROTR)) begin
      file_mem[op_addr] <= result_reg;
    end else if (wr_lane0 && sel_file && phase_reg == rsse_pkg::PH_IDLE) begin
      file_mem[file_idx] <= wb_dat_i[7:0];
    end
  end

  // Status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= rsse_pkg::FLAGS_RST;
    end else if (commit) begin
      case (opk_reg)
        rsse_pkg::OPK_ROTL,
        rsse_pkg::OPK_ROTR: flags_reg.carry <= res_carry_reg;
        rsse_pkg::OPK_SUBL: begin
          flags_reg.carry       <= res_carry_reg;
          flags_reg.digit_carry <= res_dcarry_reg;
          flags_reg.zero        <= res_zero_reg;
        end
        rsse_pkg::OPK_SLEEP: begin
          flags_reg.timeout   <= 1'b1;
          flags_reg.powerdown <= 1'b0;
        end
        default: flags_reg <= flags_reg;
      endcase
    end else if (wr_lane0 && !sel_file && reg_adr == rsse_pkg::ADR_STATUS
                 && phase_reg == rsse_pkg::PH_IDLE) begin
      flags_reg.carry       <= wb_dat_i[rsse_pkg::ST_CARRY];
      flags_reg.digit_carry <= wb_dat_i[rsse_pkg::ST_DCARRY];
      flags_reg.zero        <= wb_dat_i[rsse_pkg::ST_ZERO];
    end
  end

  // Idle state: instruction clock stopped until software wakes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asleep_reg <= 1'b0;
    end else if (commit && opk_reg == rsse_pkg::OPK_SLEEP) begin
      asleep_reg <= 1'b1;
    end else if (wake_wr) begin
      asleep_reg <= 1'b0;
    end
  end

  // Watchdog runs on its own and is cleared by power-down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg <= rsse_pkg::PRESC_CLEAR_VAL;
    end else if (commit && opk_reg == rsse_pkg::OPK_SLEEP) begin
      presc_reg <= rsse_pkg::PRESC_CLEAR_VAL;
    end else begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_counter_reg <= rsse_pkg::WDOG_CLEAR_VAL;
    end else if (commit && opk_reg == rsse_pkg::OPK_SLEEP) begin
      watchdog_counter_reg <= rsse_pkg::WDOG_CLEAR_VAL;
    end else if (presc_reg == rsse_pkg::PRESC_WRAP) begin
      watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retired_reg <= 16'h0000;
    end else if (commit) begin
      retired_reg <= retired_reg + 16'h0001;
    end
  end

  // Read mux
  assign status_word = {1'b0, (phase_reg != rsse_pkg::PH_IDLE), asleep_reg,
                        flags_reg.timeout, flags_reg.powerdown, flags_reg.zero,
                        flags_reg.digit_carry, flags_reg.carry};

  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_file) begin
      rd_data = {24'h00_0000, file_mem[file_idx]};
    end else begin
      case (reg_adr)
        rsse_pkg::ADR_INSTR:   rd_data = {18'h0_0000, instr_reg};
        rsse_pkg::ADR_ACCUM:   rd_data = {24'h00_0000, accum_reg};
        rsse_pkg::ADR_STATUS:  rd_data = {24'h00_0000, status_word};
        rsse_pkg::ADR_WDOG:    rd_data = {16'h0000, presc_reg, watchdog_counter_reg};
        rsse_pkg::ADR_RETIRED: rd_data = {16'h0000, retired_reg};
        default:               rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_o <= 1'b0;
      busy_o  <= 1'b0;
    end else begin
      sleep_o <= (commit && opk_reg == rsse_pkg::OPK_SLEEP) ? 1'b1
                 : (asleep_reg && !wake_wr);
      busy_o  <= (phase_next != rsse_pkg::PH_IDLE);
    end
  end

endmodule // rsse_core

`default_nettype wire

// ===== rsse_core_checker.sv
`timescale 1ns/1ps
`default_nettype none

module rsse_core_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sleep_o,
  input wire logic        busy_o
);
  logic taken;
  logic instr_taken;

  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign instr_taken = taken && wb_we_i && (wb_adr_i[9:2] == 8'h00) && (wb_sel_i[1:0] == 2'h3);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_next_cycle: assert property (taken |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_busy_four_phases: assert property ($rose(busy_o) |-> busy_o [*4] ##1 !busy_o)
    else $error("instruction did not take four phases");
  a_busy_from_write: assert property ($rose(busy_o) |-> $past(instr_taken))
    else $error("busy rose without an instruction write");
  a_sleep_after_exec: assert property ($rose(sleep_o) |-> $past(busy_o) && !busy_o)
    else $error("sleep not entered at end of fourth phase");
  a_sleep_refuses_instr: assert property (sleep_o && instr_taken |=> !busy_o)
    else $error("instruction started while asleep");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !sleep_o && !busy_o)
    else $error("outputs active after reset");

  c_sleep_entry: cover property ($rose(sleep_o));
  c_instr_run: cover property ($rose(busy_o));
  c_write_acked: cover property (wb_ack_o && wb_we_i);
endmodule // rsse_core_checker

bind rsse_core rsse_core_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_o(sleep_o), .busy_o(busy_o)
);

`default_nettype wire

// ===== tb_rotate_subtract_sleep_exec.sv
`timescale 1ns/1ps
`default_nettype none

module tb_rotate_subtract_sleep_exec;
  localparam logic [9:0] A_INS = rsse_pkg::ADR_INSTR;
  localparam logic [9:0] A_ACC = rsse_pkg::ADR_ACCUM;
  localparam logic [9:0] A_ST  = rsse_pkg::ADR_STATUS;
  localparam logic [9:0] A_F5  = 10'h214;
  localparam logic [9:0] A_F7F = 10'h3FC;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sleep_o;
  logic        busy_o;
  logic [31:0] rd;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  rsse_core u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_o(sleep_o), .busy_o(busy_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Run ceiling, a few times the expected length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic we, input logic [9:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [9:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask

  task automatic rdchk(input string name, input logic [9:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0000_0000);
    check(name, rd, exp);
  endtask

  task automatic exec(input logic [13:0] ins);
    wr(A_INS, {18'h00000, ins});
    while (busy_o !== 1'b0) @(posedge clk_i);
  endtask

  task automatic sub(input logic [7:0] acc, input logic [13:0] ins, input logic [7:0] res,
                     input logic [7:0] st);
    wr(A_ACC, {24'h000000, acc});
    wr(A_ST, 32'h0000_0000);
    exec(ins);
    rdchk("sub_accum", A_ACC, {24'h000000, res});
    rdchk("sub_status", A_ST, {24'h000000, st});
  endtask

  initial begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("status_reset", A_ST, 32'h0000_0018);
    rdchk("unmapped", 10'h100, 32'h0000_0000);
    wr(A_F5, 32'h0000_00E6);
    wr(A_ST, 32'h0000_0006);
    exec(14'h0D05);
    rdchk("rotl_accum", A_ACC, 32'h0000_00CC);
    rdchk("rotl_status", A_ST, 32'h0000_001F);
    rdchk("rotl_source", A_F5, 32'h0000_00E6);
    exec(14'h0C85);
    rdchk("rotr_file", A_F5, 32'h0000_00F3);
    rdchk("rotr_accum", A_ACC, 32'h0000_00CC);
    rdchk("rotr_status", A_ST, 32'h0000_001E);
    wr(A_F7F, 32'h0000_0080);
    exec(14'h0DFF);
    rdchk("rotl_top_file", A_F7F, 32'h0000_0000);
    rdchk("rotl_top_status", A_ST, 32'h0000_001F);
    sub(8'h01, 14'h3C02, 8'h01, 8'h1B);
    sub(8'h02, 14'h3D02, 8'h00, 8'h1F);
    sub(8'h03, 14'h3C02, 8'hFF, 8'h18);
    sub(8'h01, 14'h3D10, 8'h0F, 8'h19);
    wr(A_ACC, 32'h0000_0001);
    xfer(1'b1, A_INS, 32'h0000_3C02);
    check("busy", {31'h0, busy_o}, 32'h0000_0001);
    wr(A_ACC, 32'h0000_0055);
    while (busy_o !== 1'b0) @(posedge clk_i);
    rdchk("accum_busy", A_ACC, 32'h0000_0001);
    exec(14'h0000);
    rdchk("nop_accum", A_ACC, 32'h0000_0001);
    rdchk("retired", rsse_pkg::ADR_RETIRED, 32'h0000_0009);
    repeat (300) @(posedge clk_i);
    exec(14'h0063);
    check("sleep_o", {31'h0, sleep_o}, 32'h0000_0001);
    xfer(1'b0, rsse_pkg::ADR_WDOG, 32'h0000_0000);
    check("wdog_count", {24'h000000, rd[7:0]}, 32'h0000_0000);
    check("presc_low", {31'h0, rd[15:8] < 8'h10}, 32'h0000_0001);
    rdchk("sleep_status", A_ST, 32'h0000_0033);
    xfer(1'b1, A_INS, 32'h0000_3CFF);
    repeat (6) @(posedge clk_i);
    rdchk("accum_asleep", A_ACC, 32'h0000_0001);
    wr(A_ST, 32'h0000_0000);
    check("wake", {31'h0, sleep_o}, 32'h0000_0000);
    rdchk("wake_status", A_ST, 32'h0000_0010);
    tally_and_finish();
  end
endmodule // tb_rotate_subtract_sleep_exec

`default_nettype wire
